/* logic/drb_pkg.sv */
package drb_pkg;
  // ************************************************************
  // Widths and depths
  // ************************************************************
  localparam int DRB_DQ_W = 8;
  localparam int DRB_BANK_W = 3;
  localparam int DRB_COL_W = 6;
  localparam int DRB_ROW_W = 14;
  localparam int DRB_BANKS = 8;
  localparam int DRB_SLOTS = 16;
  localparam int DRB_MEM_AW = DRB_BANK_W + DRB_COL_W;
  localparam int DRB_ERR_W = 8;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] DRB_REG_MODE = 8'h00;
  localparam logic [7:0] DRB_REG_STATUS = 8'h04;
  localparam logic [7:0] DRB_REG_CTRL = 8'h08;
  localparam logic [7:0] DRB_REG_MEM_ADDR = 8'h0c;
  localparam logic [7:0] DRB_REG_MEM_DATA = 8'h10;
  localparam int DRB_CTRL_ERR_CLR = 0;
  localparam int DRB_MODE_AL_LSB = 4;
  localparam int DRB_MODE_BL8 = 8;
  localparam int DRB_MODE_BT = 9;
  localparam int DRB_STAT_STATE_LSB = 8;
  localparam int DRB_STAT_ERR_LSB = 16;

  // ************************************************************
  // Mode register load fields (address bits)
  // ************************************************************
  localparam int DRB_MR_BL_LSB = 0;
  localparam int DRB_MR_BT = 3;
  localparam int DRB_MR_CL_LSB = 4;
  localparam int DRB_EMR_AL_LSB = 3;
  localparam int DRB_AP_BIT = 10;
  localparam logic [2:0] DRB_MR_BL4 = 3'h2;
  localparam logic [2:0] DRB_MR_BL8 = 3'h3;
  localparam logic [2:0] DRB_BA_MR = 3'h0;
  localparam logic [2:0] DRB_BA_EMR = 3'h1;

  // ************************************************************
  // Reset values and burst geometry
  // ************************************************************
  localparam logic [3:0] DRB_CL_RST = 4'h3;
  localparam logic [3:0] DRB_AL_RST = 4'h0;
  localparam logic [1:0] DRB_LAST_BL4 = 2'h1;
  localparam logic [1:0] DRB_LAST_BL8 = 2'h3;
  localparam logic [1:0] DRB_INTR_BEAT = 2'h1;
  localparam logic [2:0] DRB_MASK_BL4 = 3'h3;
  localparam logic [2:0] DRB_MASK_BL8 = 3'h7;

  typedef enum logic [2:0] {
    DRB_CMD_NOP = 3'b000,
    DRB_CMD_ACT = 3'b001,
    DRB_CMD_READ = 3'b010,
    DRB_CMD_WRITE = 3'b011,
    DRB_CMD_PRE = 3'b100,
    DRB_CMD_MRS = 3'b101
  } drb_cmd_kind_t;

  typedef enum logic [1:0] {
    DRB_ST_IDLE = 2'b00,
    DRB_ST_PRE = 2'b01,
    DRB_ST_DATA = 2'b10,
    DRB_ST_POST = 2'b11
  } drb_state_t;

  typedef struct packed {
    drb_cmd_kind_t kind;
    logic [DRB_BANK_W-1:0] bank;
    logic [DRB_ROW_W-1:0] addr;
  } drb_cmd_t;

  typedef struct packed {
    logic valid;
    logic [DRB_BANK_W-1:0] bank;
    logic [DRB_COL_W-1:0] col;
    logic bl8;
    logic bt;
    logic ap;
  } drb_burst_t;

  typedef struct packed {
    logic [DRB_DQ_W-1:0] dq_rise;
    logic [DRB_DQ_W-1:0] dq_fall;
    logic dq_oe;
    logic dqs_rise;
    logic dqs_fall;
    logic dqs_n_rise;
    logic dqs_n_fall;
    logic dqs_oe;
  } drb_rd_out_t;
endpackage : drb_pkg

/* logic/drb_read_burst.sv */
// Overview of operation
// - Read carries bank, column, auto precharge choice
// - Auto precharge closes row after burst
// - First data after AL plus CL clocks
// - AL and CL set by mode loads
// - Two data elements per clock cycle
// - Strobe low before data as preamble
// - Strobe low for one clock after last element as postamble
// - Data lines released when burst ends
// - Read every BL/2 clocks streams gaplessly
// - Burst eight cut only by read
// - Interrupting read any bank, any precharge
// - Random column reads, concurrent auto precharge
//
// The address map and register access over Avalon-MM were decided locally.
module drb_read_burst
  import drb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire drb_cmd_t cmd,
  output drb_rd_out_t rd_out,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ************************************************************
  // Declarations
  // ************************************************************
  logic [3:0] cl_q;
  logic [3:0] al_q;
  logic bl8_q;
  logic bt_q;
  logic [DRB_BANKS-1:0] open_q;
  logic [DRB_BANKS-1:0] open_d;
  logic [DRB_ERR_W-1:0] err_q;
  logic [DRB_MEM_AW-1:0] mem_addr_q;
  logic [DRB_DQ_W-1:0] mem [2**DRB_MEM_AW];
  drb_burst_t slot_q [DRB_SLOTS];
  drb_burst_t cur_q;
  drb_burst_t nxt_burst;
  drb_state_t state_q;
  drb_state_t nxt_state;
  logic [1:0] beat_q;
  logic [1:0] nxt_beat;
  drb_rd_out_t out_d;
  drb_rd_out_t out_q;
  logic [31:0] rdata_q;
  logic wait_q;

  // ************************************************************
  // Command decode
  // ************************************************************
  wire is_read = (cmd.kind == DRB_CMD_READ);
  wire is_act = (cmd.kind == DRB_CMD_ACT);
  wire is_pre = (cmd.kind == DRB_CMD_PRE);
  wire is_write = (cmd.kind == DRB_CMD_WRITE);
  wire is_mr = (cmd.kind == DRB_CMD_MRS) && (cmd.bank == DRB_BA_MR);
  wire is_emr = (cmd.kind == DRB_CMD_MRS) && (cmd.bank == DRB_BA_EMR);
  wire [4:0] rd_lat = {1'b0, al_q} + {1'b0, cl_q};
  wire [4:0] ins_idx = rd_lat - 5'h01;
  wire lat_ok = (rd_lat != 5'h00) && (ins_idx < 5'(DRB_SLOTS));
  wire bank_open = open_q[cmd.bank];
  wire rd_take = is_read && bank_open && lat_ok;
  wire [2:0] mr_bl = cmd.addr[DRB_MR_BL_LSB +: 3];

  drb_burst_t new_burst;
  assign new_burst.valid = 1'b1;
  assign new_burst.bank = cmd.bank;
  assign new_burst.col = cmd.addr[DRB_COL_W-1:0];
  assign new_burst.bl8 = bl8_q;
  assign new_burst.bt = bt_q;
  assign new_burst.ap = cmd.addr[DRB_AP_BIT];

  // ************************************************************
  // Mode registers loaded by commands
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cl_q <= DRB_CL_RST;
      al_q <= DRB_AL_RST;
      bl8_q <= 1'b0;
      bt_q <= 1'b0;
    end else if (is_mr) begin
      cl_q <= {1'b0, cmd.addr[DRB_MR_CL_LSB +: 3]};
      bl8_q <= (mr_bl == DRB_MR_BL8);
      bt_q <= cmd.addr[DRB_MR_BT];
    end else if (is_emr) begin
      al_q <= {1'b0, cmd.addr[DRB_EMR_AL_LSB +: 3]};
    end
  end

  // ************************************************************
  // Latency delay line
  // ************************************************************
  for (genvar i = 0; i < DRB_SLOTS; i++) begin : g_slot
    drb_burst_t slot_d;
    if (i == DRB_SLOTS - 1) begin : g_top
      assign slot_d = (rd_take && ins_idx == 5'(i)) ? new_burst : '0;
    end else begin : g_mid
      assign slot_d = (rd_take && ins_idx == 5'(i)) ? new_burst : slot_q[i+1];
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        slot_q[i] <= '0;
      end else begin
        slot_q[i] <= slot_d;
      end
    end
  end

  // ************************************************************
  // Burst sequencing
  // ************************************************************
  wire [1:0] last_beat = cur_q.bl8 ? DRB_LAST_BL8 : DRB_LAST_BL4;
  wire in_data = (state_q == DRB_ST_DATA);
  wire at_last = in_data && (beat_q == last_beat);
  wire start = slot_q[0].valid;
  wire legal_cut = cur_q.bl8 && !cur_q.ap && (beat_q == DRB_INTR_BEAT);
  wire cut = start && in_data && !at_last;
  wire bad_cut = cut && !legal_cut;
  wire finish = at_last && !start;
  wire close_row = at_last && cur_q.ap;

  always_comb begin
    nxt_burst = cur_q;
    nxt_beat = 2'h0;
    nxt_state = DRB_ST_IDLE;
    if (start) begin
      nxt_burst = slot_q[0];
      nxt_state = DRB_ST_DATA;
    end else if (in_data && !at_last) begin
      nxt_beat = beat_q + 2'h1;
      nxt_state = DRB_ST_DATA;
    end else if (slot_q[1].valid) begin
      nxt_state = DRB_ST_PRE;
    end else if (finish) begin
      nxt_state = DRB_ST_POST;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DRB_ST_IDLE;
      beat_q <= 2'h0;
      cur_q <= '0;
    end else begin
      state_q <= nxt_state;
      beat_q <= nxt_beat;
      cur_q <= nxt_burst;
    end
  end

  // ************************************************************
  // Column order within a burst
  // ************************************************************
  function automatic logic [DRB_COL_W-1:0] elem_col(input logic [DRB_COL_W-1:0] col, input logic bl8,
                                                   input logic bt, input logic [2:0] idx);
    logic [2:0] mask;
    logic [2:0] ofs;
    logic [2:0] pos;
    mask = bl8 ? DRB_MASK_BL8 : DRB_MASK_BL4;
    ofs = col[2:0] & mask;
    pos = (bt ? (ofs ^ idx) : 3'(ofs + idx)) & mask;
    return {col[DRB_COL_W-1:3], (col[2:0] & ~mask) | pos};
  endfunction : elem_col

  wire [2:0] idx_r = {nxt_beat, 1'b0};
  wire [2:0] idx_f = {nxt_beat, 1'b1};
  wire [DRB_MEM_AW-1:0] addr_r = {nxt_burst.bank, elem_col(nxt_burst.col, nxt_burst.bl8, nxt_burst.bt, idx_r)};
  wire [DRB_MEM_AW-1:0] addr_f = {nxt_burst.bank, elem_col(nxt_burst.col, nxt_burst.bl8, nxt_burst.bt, idx_f)};
  wire drive_data = (nxt_state == DRB_ST_DATA);
  wire drive_strobe = (nxt_state != DRB_ST_IDLE);

  // ************************************************************
  // Pin drive
  // ************************************************************
  always_comb begin
    out_d = '0;
    out_d.dq_oe = drive_data;
    out_d.dqs_oe = drive_strobe;
    out_d.dqs_n_rise = drive_strobe;
    out_d.dqs_n_fall = drive_strobe;
    if (drive_data) begin
      out_d.dq_rise = mem[addr_r];
      out_d.dq_fall = mem[addr_f];
      out_d.dqs_rise = 1'b1;
      out_d.dqs_n_rise = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign rd_out = out_q;

  // ************************************************************
  // Open row tracking
  // ************************************************************
  always_comb begin
    open_d = open_q;
    if (close_row) begin
      open_d[cur_q.bank] = 1'b0;
    end
    if (is_pre) begin
      if (cmd.addr[DRB_AP_BIT]) begin
        open_d = '0;
      end else begin
        open_d[cmd.bank] = 1'b0;
      end
    end
    if (is_act) begin
      open_d[cmd.bank] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      open_q <= '0;
    end else begin
      open_q <= open_d;
    end
  end

  // ************************************************************
  // Protocol error count
  // ************************************************************
  wire rd_closed = is_read && !bank_open;
  wire wr_clash = is_write && (in_data || start);
  wire pre_clash = is_pre && in_data && cur_q.bank == cmd.bank;
  wire err_evt = bad_cut || rd_closed || wr_clash || pre_clash || (is_read && !lat_ok);
  wire bus_ack = !wait_q;
  wire wr_ok = avs_write && bus_ack;
  wire err_clr = wr_ok && (avs_address == DRB_REG_CTRL) && avs_writedata[DRB_CTRL_ERR_CLR];
  wire err_sat = &err_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= '0;
    end else if (err_evt) begin
      err_q <= err_clr ? DRB_ERR_W'(1) : (err_sat ? err_q : err_q + DRB_ERR_W'(1));
    end else if (err_clr) begin
      err_q <= '0;
    end
  end

  // ************************************************************
  // Avalon-MM slave
  // ************************************************************
  wire sel_mode = (avs_address == DRB_REG_MODE);
  wire sel_stat = (avs_address == DRB_REG_STATUS);
  wire sel_addr = (avs_address == DRB_REG_MEM_ADDR);
  wire sel_data = (avs_address == DRB_REG_MEM_DATA);
  wire [31:0] mode_word = {22'h0, bt_q, bl8_q, al_q, cl_q};
  wire [31:0] stat_word = {8'h0, err_q, 6'h0, state_q, open_q};
  wire [31:0] rd_mux = sel_mode ? mode_word :
                       sel_stat ? stat_word :
                       sel_addr ? 32'(mem_addr_q) :
                       sel_data ? 32'(mem[mem_addr_q]) : 32'h0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
      if (avs_read && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr_q <= '0;
    end else if (wr_ok && sel_addr) begin
      mem_addr_q <= avs_writedata[DRB_MEM_AW-1:0];
    end else if (wr_ok && sel_data) begin
      mem_addr_q <= mem_addr_q + DRB_MEM_AW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_ok && sel_data) begin
      mem[mem_addr_q] <= avs_writedata[DRB_DQ_W-1:0];
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
endmodule : drb_read_burst

/* verification/drb_ctrl_model.sv */
module drb_ctrl_model
  import drb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  output drb_cmd_t cmd,
  input wire drb_rd_out_t rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  drb_cmd_t q[$];
  logic [7:0] beats[$];
  // ****************************************
  // Command issue and data capture
  // ****************************************
  task automatic send(input drb_cmd_kind_t k, input logic [2:0] b, input logic [13:0] a);
    q.push_back('{kind: k, bank: b, addr: a});
  endtask : send
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
    end else begin
      cmd <= (q.size() > 0) ? q.pop_front() : '0;
      if (rd_out.dq_oe) begin
        beats.push_back(rd_out.dq_rise);
        beats.push_back(rd_out.dq_fall);
      end
    end
  end
endmodule : drb_ctrl_model

/* verification/drb_read_burst_checker.sv */
module drb_read_burst_checker
  import drb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire drb_cmd_t cmd,
  input wire drb_rd_out_t rd_out,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Latency tracking
  // ****************************************
  logic [15:0] hist_q;
  logic [2:0] cl_q;
  logic [2:0] al_q;
  logic [3:0] rl;
  assign rl = {1'b0, al_q} + {1'b0, cl_q};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hist_q <= '0;
      cl_q <= 3'h3;
      al_q <= 3'h0;
    end else begin
      hist_q <= {hist_q[14:0], cmd.kind == DRB_CMD_READ};
      if (cmd.kind == DRB_CMD_MRS && cmd.bank == DRB_BA_MR) begin
        cl_q <= cmd.addr[6:4];
      end
      if (cmd.kind == DRB_CMD_MRS && cmd.bank == DRB_BA_EMR) begin
        al_q <= cmd.addr[5:3];
      end
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_strobe_data: assert property (rd_out.dq_oe |-> rd_out.dqs_oe && rd_out.dqs_rise && !rd_out.dqs_fall)
    else $error("data beat without strobe");
  a_dqs_pair: assert property (rd_out.dqs_oe |-> rd_out.dqs_n_rise == !rd_out.dqs_rise && rd_out.dqs_n_fall == !rd_out.dqs_fall)
    else $error("strobe complement wrong");
  a_pre_latency: assert property ($rose(rd_out.dqs_oe) |-> hist_q[rl - 4'h1] && !rd_out.dq_oe && !rd_out.dqs_rise)
    else $error("preamble at wrong cycle");
  a_first_data: assert property ($rose(rd_out.dq_oe) |-> hist_q[rl] && $past(rd_out.dqs_oe))
    else $error("first data not at read latency");
  a_gap_free: assert property (rd_out.dq_oe && hist_q[rl - 4'h1] |=> rd_out.dq_oe)
    else $error("gap between streamed bursts");
  a_post_amble: assert property ($fell(rd_out.dq_oe) |-> rd_out.dqs_oe && !rd_out.dqs_rise && !rd_out.dqs_fall)
    else $error("postamble missing");
  a_idle_zero: assert property (!rd_out.dq_oe |-> rd_out.dq_rise == '0 && rd_out.dq_fall == '0)
    else $error("data lines not released");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
  c_data: cover property ($rose(rd_out.dq_oe));
  c_stream: cover property (rd_out.dq_oe && hist_q[rl - 4'h1]);
  c_bus: cover property (avs_read && !avs_waitrequest);
endmodule : drb_read_burst_checker

bind drb_read_burst drb_read_burst_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd), .rd_out(rd_out),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

/* verification/drb_read_burst_test.sv */
module drb_read_burst_test
  import drb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
  logic clk_sys;
  logic rst_n;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rdat;
  drb_cmd_t cmd;
  drb_rd_out_t rd_out;
  int n_errors;
  int num_checks;
  int cycles;
  logic [7:0] exp_q[$];

  drb_read_burst u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd), .rd_out(rd_out), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  drb_ctrl_model u_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd), .rd_out(rd_out));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rdat)
  endtask : rd_chk

  function automatic logic [5:0] col_at(logic [5:0] s, int i, logic bl8, logic bt);
    logic [5:0] m;
    m = bl8 ? 6'h07 : 6'h03;
    return bt ? (s ^ 6'(i)) : ((s & ~m) | ((s + 6'(i)) & m));
  endfunction : col_at

  task automatic add_exp(input logic [2:0] b, input logic [5:0] s, input int n, input logic bl8, input logic bt);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({1'b0, b[0], col_at(s, i, bl8, bt)});
    end
  endtask : add_exp

  task automatic check_beats(input string nm);
    int n;
    n = 0;
    while (u_ctrl.beats.size() < exp_q.size() && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (8) @(posedge clk_sys);
    `CHK("beat count", exp_q.size(), u_ctrl.beats.size())
    foreach (exp_q[i]) begin
      `CHK(nm, exp_q[i], u_ctrl.beats[i])
    end
    exp_q.delete();
    u_ctrl.beats.delete();
    $display("test %s done", nm);
  endtask : check_beats

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk("mode reset", DRB_REG_MODE, 32'h00000003);
    rd_chk("unmapped", 8'h20, 32'h00000000);
    bus(1'b1, DRB_REG_MEM_ADDR, 32'h0);
    for (int i = 0; i < 128; i++) begin
      bus(1'b1, DRB_REG_MEM_DATA, 32'(i));
    end
    rd_chk("mem addr", DRB_REG_MEM_ADDR, 32'h00000080);
    bus(1'b1, DRB_REG_MEM_ADDR, 32'h45);
    rd_chk("mem data", DRB_REG_MEM_DATA, 32'h00000045);
    u_ctrl.send(DRB_CMD_READ, 3'h0, 14'h0001);
    repeat (4) @(posedge clk_sys);
    rd_chk("closed bank", DRB_REG_STATUS, 32'h00010000);
    check_beats("closed bank");
    bus(1'b1, DRB_REG_CTRL, 32'h1);
    u_ctrl.send(DRB_CMD_ACT, 3'h0, 14'h0000);
    u_ctrl.send(DRB_CMD_NOP, 3'h0, 14'h0000);
    u_ctrl.send(DRB_CMD_READ, 3'h0, 14'h0001);
    add_exp(3'h0, 6'h01, 4, 1'b0, 1'b0);
    check_beats("bl4 seq");
    u_ctrl.send(DRB_CMD_READ, 3'h0, 14'h0004);
    u_ctrl.send(DRB_CMD_NOP, 3'h0, 14'h0000);
    u_ctrl.send(DRB_CMD_READ, 3'h0, 14'h0009);
    add_exp(3'h0, 6'h04, 4, 1'b0, 1'b0);
    add_exp(3'h0, 6'h09, 4, 1'b0, 1'b0);
    check_beats("gapless");
    u_ctrl.send(DRB_CMD_MRS, DRB_BA_MR, 14'h003a);
    u_ctrl.send(DRB_CMD_NOP, 3'h0, 14'h0000);
    u_ctrl.send(DRB_CMD_READ, 3'h0, 14'h0006);
    add_exp(3'h0, 6'h06, 4, 1'b0, 1'b1);
    check_beats("interleave");
    rd_chk("mode interleave", DRB_REG_MODE, 32'h00000203);
    u_ctrl.send(DRB_CMD_MRS, DRB_BA_MR, 14'h0043);
    u_ctrl.send(DRB_CMD_MRS, DRB_BA_EMR, 14'h0010);
    u_ctrl.send(DRB_CMD_NOP, 3'h0, 14'h0000);
    u_ctrl.send(DRB_CMD_READ, 3'h0, 14'h0003);
    add_exp(3'h0, 6'h03, 8, 1'b1, 1'b0);
    check_beats("bl8 al2");
    rd_chk("mode bl8", DRB_REG_MODE, 32'h00000124);
    u_ctrl.send(DRB_CMD_ACT, 3'h1, 14'h0000);
    u_ctrl.send(DRB_CMD_NOP, 3'h0, 14'h0000);
    u_ctrl.send(DRB_CMD_READ, 3'h0, 14'h0008);
    u_ctrl.send(DRB_CMD_NOP, 3'h0, 14'h0000);
    u_ctrl.send(DRB_CMD_READ, 3'h1, 14'h0400);
    add_exp(3'h0, 6'h08, 4, 1'b1, 1'b0);
    add_exp(3'h1, 6'h00, 8, 1'b1, 1'b0);
    check_beats("interrupt");
    rd_chk("open banks", DRB_REG_STATUS, 32'h00000001);
    u_ctrl.send(DRB_CMD_READ, 3'h0, 14'h0010);
    add_exp(3'h0, 6'h10, 8, 1'b1, 1'b0);
    check_beats("read then precharge");
    u_ctrl.send(DRB_CMD_PRE, 3'h0, 14'h0000);
    u_ctrl.send(DRB_CMD_WRITE, 3'h1, 14'h0000);
    repeat (4) @(posedge clk_sys);
    rd_chk("precharged", DRB_REG_STATUS, 32'h00000000);
    wrap_up();
  end
endmodule : drb_read_burst_test
